// [hw/drl_core.sv]
/*
  Per-channel reference selection, shutdown decoding, tap code output and
  lock status readback for an eight-channel ladder DAC.
  Assumes nonvolatile lock and reference bits arrive as static levels from
  another domain, and the register port is driven on clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Lock pair reads 11, 10, 01 or 00 from tap-lock and settings-lock bits.
// - Lock pairs mirror the nonvolatile lock bits, cleared by default.
// - Channel 0 in lowest pair; channel 7 in the top pair, bits 15:14.
// - The volatile DAC value register selects the ladder tap position.
// - Highest tap code is all ones, one element below the top node.
// - A powered-down channel is disconnected from its reference.
// - Two bits per channel pick supply, band gap, external unbuffered or buffered.
// - After every reset the nonvolatile reference selection is copied to volatile.
// - With supply selected the external reference pin stays disconnected.
// - Shutdown field: 00 normal, 01 1k load, 10 125k load, 11 open.
module drl_core (
  // Clock and reset.
  input  wire logic                                       clk_sys_i,
  input  wire logic                                       rst_i,
  // Register port.
  input  wire logic [drl_pkg::ADDR_BITS-1:0]              reg_addr_i,
  input  wire logic                                       reg_wr_i,
  input  wire logic                                       reg_rd_i,
  input  wire logic [drl_pkg::DATA_BITS-1:0]              reg_wdata_i,
  output logic      [drl_pkg::DATA_BITS-1:0]              reg_rdata_o,
  output logic                                            reg_rvalid_o,
  // Nonvolatile configuration levels.
  input  wire logic [drl_pkg::CH_COUNT-1:0]               nv_tap_lock_cfg_i,
  input  wire logic [drl_pkg::CH_COUNT-1:0]               nv_settings_lock_cfg_i,
  input  wire logic [2*drl_pkg::CH_COUNT-1:0]             nv_ref_source_select_i,
  // Ladder controls.
  output logic      [drl_pkg::CH_COUNT*drl_pkg::RES_BITS-1:0] tap_code_o,
  output logic      [drl_pkg::CH_COUNT-1:0]               ladder_connect_o,
  output logic      [drl_pkg::CH_COUNT-1:0]               ref_vdd_o,
  output logic      [drl_pkg::CH_COUNT-1:0]               ref_bandgap_o,
  output logic      [drl_pkg::CH_COUNT-1:0]               ref_ext_unbuf_o,
  output logic      [drl_pkg::CH_COUNT-1:0]               ref_ext_buf_o,
  output logic      [drl_pkg::CH_COUNT-1:0]               load_1k_o,
  output logic      [drl_pkg::CH_COUNT-1:0]               load_125k_o,
  output logic      [drl_pkg::CH_COUNT-1:0]               out_open_o,
  output logic                                            ready_o
);
  import drl_pkg::*;

  // ***************************************************************
  // Functions
  // ***************************************************************
  // One-hot of a two-bit code: bit k set when the code equals k.
  function automatic logic [3:0] onehot4(input logic [1:0] code);
    logic [3:0] v;
    v = 4'h0;
    v[code] = 1'b1;
    return v;
  endfunction : onehot4

  // ***************************************************************
  // Nonvolatile input synchronisers
  // ***************************************************************
  logic [CH_COUNT-1:0]   tl_meta_r;
  logic [CH_COUNT-1:0]   tl_sync_r;
  logic [CH_COUNT-1:0]   sl_meta_r;
  logic [CH_COUNT-1:0]   sl_sync_r;
  logic [2*CH_COUNT-1:0] rs_meta_r;
  logic [2*CH_COUNT-1:0] rs_sync_r;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tl_meta_r <= '0;
      tl_sync_r <= '0;
      sl_meta_r <= '0;
      sl_sync_r <= '0;
      rs_meta_r <= '0;
      rs_sync_r <= '0;
    end else begin
      tl_meta_r <= nv_tap_lock_cfg_i;
      tl_sync_r <= tl_meta_r;
      sl_meta_r <= nv_settings_lock_cfg_i;
      sl_sync_r <= sl_meta_r;
      rs_meta_r <= nv_ref_source_select_i;
      rs_sync_r <= rs_meta_r;
    end
  end

  // ***************************************************************
  // Recall sequencer
  // ***************************************************************
  drl_state_type state_r;
  logic [1:0]    recall_cnt_r;
  logic          recall_now;

  assign recall_now = (state_r == DRL_RECALL) && (recall_cnt_r == RECALL_CYCLES - 2'h1);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r      <= DRL_RECALL;
      recall_cnt_r <= 2'h0;
    end else begin
      case (state_r)
        DRL_RECALL: begin
          recall_cnt_r <= recall_cnt_r + 2'h1;
          if (recall_now) begin
            state_r <= DRL_RUN;
          end
        end
        DRL_RUN: begin
          recall_cnt_r <= recall_cnt_r;
        end
        default: begin
          state_r <= DRL_RECALL;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= (state_r == DRL_RUN) || recall_now;
    end
  end

  // ***************************************************************
  // Volatile registers
  // ***************************************************************
  logic [RES_BITS-1:0]   tap_r [CH_COUNT];
  logic [2*CH_COUNT-1:0] ref_sel_r;
  logic [2*CH_COUNT-1:0] shutdown_r;
  logic [2*CH_COUNT-1:0] lock_pairs;
  logic                  wr_ok;

  assign wr_ok = reg_wr_i && (state_r == DRL_RUN);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ref_sel_r <= REG16_RESET;
    end else if (recall_now) begin
      ref_sel_r <= rs_sync_r;
    end else if (wr_ok && reg_addr_i == ADDR_REF_SEL) begin
      ref_sel_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      shutdown_r <= REG16_RESET;
    end else if (wr_ok && reg_addr_i == ADDR_SHUTDOWN) begin
      shutdown_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < CH_COUNT; i++) begin
        tap_r[i] <= TAP_RESET;
      end
    end else if (wr_ok && reg_addr_i <= ADDR_DAC_LAST) begin
      tap_r[reg_addr_i[2:0]] <= reg_wdata_i[RES_BITS-1:0];
    end
  end

  // ***************************************************************
  // Per-channel ladder decode
  // ***************************************************************
  for (genvar ch = 0; ch < CH_COUNT; ch++) begin : g_ch
    logic [1:0] rs;
    logic [1:0] sd;
    logic [3:0] rs_hot;
    logic [3:0] sd_hot;
    logic       on;

    assign rs     = ref_sel_r[2*ch +: 2];
    assign sd     = shutdown_r[2*ch +: 2];
    assign rs_hot = onehot4(rs);
    assign sd_hot = onehot4(sd);
    assign on     = sd_hot[SD_NORMAL];
    // Lock pair is {tap lock, settings lock}, channel 0 in bits 1:0.
    assign lock_pairs[2*ch +: 2] = {tl_sync_r[ch], sl_sync_r[ch]};

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        tap_code_o[ch*RES_BITS +: RES_BITS] <= TAP_RESET;
        ladder_connect_o[ch] <= 1'b0;
        ref_vdd_o[ch]        <= 1'b0;
        ref_bandgap_o[ch]    <= 1'b0;
        ref_ext_unbuf_o[ch]  <= 1'b0;
        ref_ext_buf_o[ch]    <= 1'b0;
        load_1k_o[ch]        <= 1'b0;
        load_125k_o[ch]      <= 1'b0;
        out_open_o[ch]       <= 1'b0;
      end else begin
        // Tap index equals the code; all ones leaves one element on top.
        tap_code_o[ch*RES_BITS +: RES_BITS] <= tap_r[ch];
        ladder_connect_o[ch] <= on;
        ref_vdd_o[ch]        <= on && rs_hot[REF_VDD];
        ref_bandgap_o[ch]    <= on && rs_hot[REF_BANDGAP];
        ref_ext_unbuf_o[ch]  <= on && rs_hot[REF_EXT_UNBUF];
        ref_ext_buf_o[ch]    <= on && rs_hot[REF_EXT_BUF];
        load_1k_o[ch]        <= sd_hot[SD_LOAD_1K];
        load_125k_o[ch]      <= sd_hot[SD_LOAD_125K];
        out_open_o[ch]       <= sd_hot[SD_OPEN];
      end
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o  <= REG16_RESET;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (reg_addr_i <= ADDR_DAC_LAST) begin
          reg_rdata_o <= {4'h0, tap_r[reg_addr_i[2:0]]};
        end else if (reg_addr_i == ADDR_REF_SEL) begin
          reg_rdata_o <= ref_sel_r;
        end else if (reg_addr_i == ADDR_SHUTDOWN) begin
          reg_rdata_o <= shutdown_r;
        end else if (reg_addr_i == ADDR_LOCK) begin
          reg_rdata_o <= lock_pairs;
        end else begin
          reg_rdata_o <= REG16_RESET;
        end
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  lock_read_map_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == ADDR_LOCK |=> reg_rvalid_o && reg_rdata_o[1:0] ==
      {$past(tl_sync_r[0]), $past(sl_sync_r[0])})
    else $error("lock pair readback wrong");

  lock_mirror_top_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == ADDR_LOCK |=> reg_rdata_o[15:14] ==
      {$past(tl_sync_r[7]), $past(sl_sync_r[7])})
    else $error("top lock pair not mirrored");

  lock_ro_write_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_ok && reg_addr_i == ADDR_LOCK |=> $stable(ref_sel_r) && $stable(shutdown_r))
    else $error("write to lock status changed state");

  tap_follow_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_ok && reg_addr_i == ADDR_DAC_BASE ##1 !(wr_ok && reg_addr_i == ADDR_DAC_BASE)
      |=> tap_code_o[RES_BITS-1:0] == $past(reg_wdata_i[RES_BITS-1:0], 2))
    else $error("tap code does not follow DAC value");

  pd_disconnect_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    shutdown_r[1:0] != SD_NORMAL |=> !ladder_connect_o[0] && !ref_vdd_o[0]
      && !ref_bandgap_o[0] && !ref_ext_unbuf_o[0] && !ref_ext_buf_o[0])
    else $error("powered-down ladder still connected");

  ref_onehot_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ladder_connect_o[3] |-> $onehot({ref_vdd_o[3], ref_bandgap_o[3],
      ref_ext_unbuf_o[3], ref_ext_buf_o[3]}))
    else $error("reference selection not one source");

  recall_copy_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    recall_now |=> ref_sel_r == $past(rs_sync_r) ##1 ready_o)
    else $error("nonvolatile reference not recalled");

  vdd_no_ext_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    |ref_vdd_o |-> (ref_vdd_o & (ref_ext_unbuf_o | ref_ext_buf_o)) == '0)
    else $error("external pin connected in supply mode");

  shutdown_load_a : assert property (@(posedge clk_sys_i) disable iff (rst_i)
    shutdown_r[5:4] == SD_LOAD_125K |=> load_125k_o[2] && !load_1k_o[2] && !out_open_o[2])
    else $error("shutdown load decode wrong");
endmodule : drl_core
`default_nettype wire

// [hw/drl_pkg.sv]
/*
  Shared constants for the reference-select and lock-status block of an
  eight-channel resistor-ladder DAC: register offsets, field codes, widths
  and the recall delay after reset.
  Assumes the serial framing logic delivers register addresses and data
  on the core clock.
*/
package drl_pkg;
  localparam int          CH_COUNT      = 8;
  localparam int          RES_BITS      = 12;
  localparam int          ADDR_BITS     = 5;
  localparam int          DATA_BITS     = 16;
  // Register offsets.
  localparam logic [4:0]  ADDR_DAC_BASE = 5'h00;
  localparam logic [4:0]  ADDR_DAC_LAST = 5'h07;
  localparam logic [4:0]  ADDR_REF_SEL  = 5'h08;
  localparam logic [4:0]  ADDR_SHUTDOWN = 5'h09;
  localparam logic [4:0]  ADDR_LOCK     = 5'h0B;
  // Reference source codes.
  localparam logic [1:0]  REF_VDD       = 2'h0;
  localparam logic [1:0]  REF_BANDGAP   = 2'h1;
  localparam logic [1:0]  REF_EXT_UNBUF = 2'h2;
  localparam logic [1:0]  REF_EXT_BUF   = 2'h3;
  // Shutdown codes.
  localparam logic [1:0]  SD_NORMAL     = 2'h0;
  localparam logic [1:0]  SD_LOAD_1K    = 2'h1;
  localparam logic [1:0]  SD_LOAD_125K  = 2'h2;
  localparam logic [1:0]  SD_OPEN       = 2'h3;
  // Reset values.
  localparam logic [11:0] TAP_RESET     = 12'h000;
  localparam logic [15:0] REG16_RESET   = 16'h0000;
  // Edges after reset release before the nonvolatile recall.
  localparam logic [1:0]  RECALL_CYCLES = 2'h3;

  typedef enum logic [0:0] {
    DRL_RECALL = 1'b0,
    DRL_RUN    = 1'b1
  } drl_state_type;
endpackage : drl_pkg

// [tb/drl_host.sv]
/*
  Host model driving the register port of the reference and lock block.
  Assumes the bench calls its tasks and that reads answer within a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module drl_host (
  // Clock.
  input  wire logic                          clk_sys_i,
  // Read answer.
  input  wire logic [drl_pkg::DATA_BITS-1:0] rdata_i,
  input  wire logic                          rvalid_i,
  // Request.
  output logic      [drl_pkg::ADDR_BITS-1:0] addr_o,
  output logic                               wr_o,
  output logic                               rd_o,
  output logic      [drl_pkg::DATA_BITS-1:0] wdata_o
);
  import drl_pkg::*;
  initial begin
    addr_o  = 5'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 16'h0000;
  end
  // Released data is inverted so a stale value cannot pass as held.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_sys_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output bit ok);
    int n;
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_sys_i);
    rd_o   <= 1'b0;
    ok = 1'b0;
    d  = 16'h0000;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        d  = rdata_i;
      end else begin
        @(posedge clk_sys_i);
      end
    end
  endtask : rd
endmodule : drl_host
`default_nettype wire

// [tb/drl_core_tb.sv]
/*
  Self-checking bench for the reference select and lock status block.
  Assumes the host model in drl_host and a single 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module drl_core_tb;
  import drl_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [4:0]  addr;
  logic        wr;
  logic        rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic [7:0]  nv_tap    = 8'h00;
  logic [7:0]  nv_set    = 8'h00;
  logic [15:0] nv_ref    = 16'hE4E4;
  logic [95:0] tap;
  logic [7:0]  conn, vdd, bg, eun, ebu, l1k, l125k, opn;
  logic        ready;
  int          n_fail    = 0;
  int          checked   = 0;
  logic [7:0]  row_tap[6] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h0F, 8'h03};
  logic [7:0]  row_set[6] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'hF0, 8'h01};
  logic [15:0] row_exp[6] = '{16'h0000, 16'hFFFF, 16'hAAAA, 16'h5555, 16'h55AA, 16'h000B};
  always #2 clk_sys_i = ~clk_sys_i;
  drl_host host_u (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  drl_core dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .nv_tap_lock_cfg_i(nv_tap), .nv_settings_lock_cfg_i(nv_set),
    .nv_ref_source_select_i(nv_ref), .tap_code_o(tap), .ladder_connect_o(conn),
    .ref_vdd_o(vdd), .ref_bandgap_o(bg), .ref_ext_unbuf_o(eun), .ref_ext_buf_o(ebu),
    .load_1k_o(l1k), .load_125k_o(l125k), .out_open_o(opn), .ready_o(ready));
  task automatic give_verdict;
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_out(input logic [11:0] got, input logic [11:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_out
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    bit          ok;
    host_u.rd(a, d, ok);
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED %0t read answer missing", $time);
      give_verdict();
    end
    cmp_reg(d, exp, "register read");
  endtask : rd_chk
  task automatic wait_ready;
    int n;
    for (n = 0; n < 10; n++) begin
      @(posedge clk_sys_i);
      #1;
      if (ready === 1'b1) return;
    end
    n_fail++;
    $display("CHECK FAILED %0t ready never rose", $time);
    give_verdict();
  endtask : wait_ready
  // Expected switch and load states per channel from reference and shutdown codes.
  task automatic chk_ladder(input logic [15:0] rs, input logic [15:0] sd);
    logic [7:0] e[8];
    logic [1:0] c;
    logic [1:0] s;
    for (int n = 0; n < 8; n++) begin
      c = rs[2*n+:2];
      s = sd[2*n+:2];
      e[0][n] = (s == SD_NORMAL);
      e[1][n] = (s == SD_NORMAL) && (c == REF_VDD);
      e[2][n] = (s == SD_NORMAL) && (c == REF_BANDGAP);
      e[3][n] = (s == SD_NORMAL) && (c == REF_EXT_UNBUF);
      e[4][n] = (s == SD_NORMAL) && (c == REF_EXT_BUF);
      e[5][n] = (s == SD_LOAD_1K);
      e[6][n] = (s == SD_LOAD_125K);
      e[7][n] = (s == SD_OPEN);
    end
    cmp_out({4'h0, conn}, {4'h0, e[0]}, "ladder connect");
    cmp_out({4'h0, vdd}, {4'h0, e[1]}, "supply switch");
    cmp_out({4'h0, bg}, {4'h0, e[2]}, "band gap switch");
    cmp_out({4'h0, eun}, {4'h0, e[3]}, "unbuffered switch");
    cmp_out({4'h0, ebu}, {4'h0, e[4]}, "buffered switch");
    cmp_out({4'h0, l1k}, {4'h0, e[5]}, "1k load");
    cmp_out({4'h0, l125k}, {4'h0, e[6]}, "125k load");
    cmp_out({4'h0, opn}, {4'h0, e[7]}, "open output");
  endtask : chk_ladder
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    wait_ready();
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk_ladder(16'hE4E4, 16'h0000);
    rd_chk(ADDR_REF_SEL, 16'hE4E4);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_i);
      nv_tap <= row_tap[i];
      nv_set <= row_set[i];
      repeat (3) @(posedge clk_sys_i);
      rd_chk(ADDR_LOCK, row_exp[i]);
    end
    host_u.wr(ADDR_LOCK, 16'hFFFF);
    rd_chk(ADDR_LOCK, 16'h000B);
    host_u.wr(ADDR_DAC_BASE, 16'hFFFF);
    host_u.wr(ADDR_DAC_LAST, 16'h0ABC);
    @(posedge clk_sys_i);
    #1;
    cmp_out(tap[11:0], 12'hFFF, "full scale tap");
    cmp_out(tap[95:84], 12'hABC, "last channel tap");
    rd_chk(ADDR_DAC_BASE, 16'h0FFF);
    host_u.wr(ADDR_SHUTDOWN, 16'h1BE5);
    @(posedge clk_sys_i);
    #1;
    chk_ladder(16'hE4E4, 16'h1BE5);
    rd_chk(5'h1F, 16'h0000);
    host_u.wr(ADDR_REF_SEL, 16'h0000);
    rd_chk(ADDR_REF_SEL, 16'h0000);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    wait_ready();
    rd_chk(ADDR_REF_SEL, 16'hE4E4);
    give_verdict();
  end
endmodule : drl_core_tb
`default_nettype wire
